// ### src/fbo_pkg.sv
// Purpose: Shared constants and types for the flag and bit operations unit
// Assumes: One operation per cycle, decoded by the core
// Notes: Status bit positions follow the core's status register layout
package fbo_pkg;
   localparam int FBO_W = 8;
   localparam int FBO_C = 0;
   localparam int FBO_Z = 1;
   localparam int FBO_N = 2;
   localparam int FBO_V = 3;
   localparam int FBO_S = 4;
   localparam int FBO_H = 5;
   localparam int FBO_T = 6;
   localparam int FBO_I = 7;
   localparam logic [7:0] FBO_RST_STATUS = 8'h00;
   localparam logic [7:0] FBO_RST_DATA = 8'h00;

   typedef enum logic [4:0] {
      FBO_OP_NONE = 5'h00,
      FBO_OP_ROR = 5'h01,
      FBO_OP_ARITH_SHR = 5'h02,
      FBO_OP_SWAP = 5'h03,
      FBO_OP_FSET = 5'h04,
      FBO_OP_FCLR = 5'h05,
      FBO_OP_BIT_STORE = 5'h06,
      FBO_OP_BIT_LOAD = 5'h07,
      FBO_OP_CARRY_HIGH = 5'h08,
      FBO_OP_CARRY_LOW = 5'h09,
      FBO_OP_NEG_HIGH = 5'h0A,
      FBO_OP_NEG_LOW = 5'h0B,
      FBO_OP_ZERO_HIGH = 5'h0C,
      FBO_OP_ZERO_LOW = 5'h0D,
      FBO_OP_IRQ_ON = 5'h0E,
      FBO_OP_IRQ_OFF = 5'h0F,
      FBO_OP_SIGN_HIGH = 5'h10,
      FBO_OP_SIGN_LOW = 5'h11,
      FBO_OP_OVF_HIGH = 5'h12,
      FBO_OP_OVF_LOW = 5'h13,
      FBO_OP_XFER_HIGH = 5'h14,
      FBO_OP_XFER_LOW = 5'h15
   } fbo_op_e;

   typedef struct packed {
      fbo_op_e op;
      logic [2:0] idx;
      logic [7:0] dest;
      logic [7:0] src;
   } fbo_req_s;

   typedef struct packed {
      logic [7:0] status_register;
      logic [7:0] result;
      logic result_we;
   } fbo_state_s;
endpackage : fbo_pkg

// ### src/fbo_unit.sv
// Purpose: Shift, swap, bit transfer and status flag operations
// Assumes: req is a decoded operation valid for the current cycle
// Notes: Result and status register update one edge after the request
`timescale 1ns/1ps
module fbo_unit
   import fbo_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire fbo_req_s req,
   output fbo_state_s state_out
);
   // ****************************************
   // Next state
   // ****************************************
   fbo_state_s st_reg;
   fbo_state_s st_next;
   logic [7:0] sr;
   logic [7:0] d;
   logic [7:0] res;

   always_comb begin
      sr = st_reg.status_register;
      d = req.dest;
      res = d;
      st_next = st_reg;
      st_next.result_we = 1'b0;
      unique case (req.op)
         FBO_OP_ROR: begin
            res = {sr[FBO_C], d[7:1]};
            st_next.result_we = 1'b1;
         end
         FBO_OP_ARITH_SHR: begin
            res = {d[7], d[7:1]};
            st_next.result_we = 1'b1;
         end
         FBO_OP_SWAP: begin
            res = {d[3:0], d[7:4]};
            st_next.result_we = 1'b1;
         end
         FBO_OP_FSET: sr[req.idx] = 1'b1;
         FBO_OP_FCLR: sr[req.idx] = 1'b0;
         FBO_OP_BIT_STORE: sr[FBO_T] = req.src[req.idx];
         FBO_OP_BIT_LOAD: begin
            res[req.idx] = sr[FBO_T];
            st_next.result_we = 1'b1;
         end
         FBO_OP_CARRY_HIGH: sr[FBO_C] = 1'b1;
         FBO_OP_CARRY_LOW: sr[FBO_C] = 1'b0;
         FBO_OP_NEG_HIGH: sr[FBO_N] = 1'b1;
         FBO_OP_NEG_LOW: sr[FBO_N] = 1'b0;
         FBO_OP_ZERO_HIGH: sr[FBO_Z] = 1'b1;
         FBO_OP_ZERO_LOW: sr[FBO_Z] = 1'b0;
         FBO_OP_IRQ_ON: sr[FBO_I] = 1'b1;
         FBO_OP_IRQ_OFF: sr[FBO_I] = 1'b0;
         FBO_OP_SIGN_HIGH: sr[FBO_S] = 1'b1;
         FBO_OP_SIGN_LOW: sr[FBO_S] = 1'b0;
         FBO_OP_OVF_HIGH: sr[FBO_V] = 1'b1;
         FBO_OP_OVF_LOW: sr[FBO_V] = 1'b0;
         FBO_OP_XFER_HIGH: sr[FBO_T] = 1'b1;
         FBO_OP_XFER_LOW: sr[FBO_T] = 1'b0;
         default: ;
      endcase
      // Shifts: V = N xor C, S = N xor V
      if (req.op == FBO_OP_ROR || req.op == FBO_OP_ARITH_SHR) begin
         sr[FBO_C] = d[0];
         sr[FBO_Z] = (res == 8'h00);
         sr[FBO_N] = res[7];
         sr[FBO_V] = res[7] ^ d[0];
         sr[FBO_S] = d[0];
      end
      st_next.status_register = sr;
      if (st_next.result_we) begin
         st_next.result = res;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_reg <= '{status_register: FBO_RST_STATUS, result: FBO_RST_DATA, result_we: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign state_out = st_reg;

   // ****************************************
   // Reset and write-back checks
   // ****************************************
   reset_state_a: assert property (@(posedge ref_clk)
      srst |=> st_reg.status_register == FBO_RST_STATUS && st_reg.result == FBO_RST_DATA
      && !st_reg.result_we)
      else $error("reset state wrong");
   result_we_a: assert property (@(posedge ref_clk) disable iff (srst)
      1'b1 |=> st_reg.result_we == $past(req.op inside {FBO_OP_ROR, FBO_OP_ARITH_SHR,
      FBO_OP_SWAP, FBO_OP_BIT_LOAD}))
      else $error("write strobe wrong");
   result_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
      !(req.op inside {FBO_OP_ROR, FBO_OP_ARITH_SHR, FBO_OP_SWAP, FBO_OP_BIT_LOAD})
      |=> st_reg.result == $past(st_reg.result))
      else $error("result changed without write");

   // ****************************************
   // Checks
   // ****************************************
   ror_result_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_ROR |=> st_reg.result == {$past(st_reg.status_register[FBO_C]),
      $past(req.dest[7:1])} && st_reg.status_register[FBO_C] == $past(req.dest[0]))
      else $error("rotate result wrong");
   shift_flags_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op inside {FBO_OP_ROR, FBO_OP_ARITH_SHR} |=>
      st_reg.status_register[FBO_Z] == (st_reg.result == 8'h00)
      && st_reg.status_register[FBO_N] == st_reg.result[7]
      && st_reg.status_register[FBO_V] == (st_reg.result[7] ^ $past(req.dest[0]))
      && st_reg.status_register[FBO_S] == $past(req.dest[0])
      && st_reg.status_register[FBO_H] == $past(st_reg.status_register[FBO_H])
      && st_reg.status_register[FBO_I] == $past(st_reg.status_register[FBO_I])
      && st_reg.status_register[FBO_T] == $past(st_reg.status_register[FBO_T]))
      else $error("shift flags wrong");
   ashr_sign_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_ARITH_SHR |=> st_reg.result[7] == $past(req.dest[7])
      && st_reg.result_we && st_reg.status_register[FBO_C] == $past(req.dest[0]))
      else $error("shift sign lost");
   ashr_body_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_ARITH_SHR |=> st_reg.result[6:0] == $past(req.dest[7:1]))
      else $error("shift body wrong");
   swap_flags_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_SWAP |=> st_reg.status_register == $past(st_reg.status_register)
      && st_reg.result == {$past(req.dest[3:0]), $past(req.dest[7:4])})
      else $error("swap wrong");
   fset_bit_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_FSET |=> st_reg.status_register ==
      ($past(st_reg.status_register) | (8'h01 << $past(req.idx))))
      else $error("indexed set failed");
   fclr_bit_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_FCLR |=> st_reg.status_register ==
      ($past(st_reg.status_register) & ~(8'h01 << $past(req.idx))))
      else $error("indexed clear failed");
   store_copy_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_BIT_STORE |=> st_reg.status_register[FBO_T] == $past(req.src[req.idx])
      && (st_reg.status_register & ~(8'h01 << FBO_T)) ==
      ($past(st_reg.status_register) & ~(8'h01 << FBO_T)))
      else $error("bit store wrong");
   load_flags_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_BIT_LOAD |=> st_reg.status_register == $past(st_reg.status_register))
      else $error("bit load touched flags");
   load_result_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_BIT_LOAD |=> st_reg.result_we
      && st_reg.result[$past(req.idx)] == $past(st_reg.status_register[FBO_T])
      && (st_reg.result & ~(8'h01 << $past(req.idx))) ==
      ($past(req.dest) & ~(8'h01 << $past(req.idx))))
      else $error("bit load result wrong");

   // ****************************************
   // Flag force checks
   // ****************************************
   carry_only_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_CARRY_HIGH |=> st_reg.status_register ==
      ($past(st_reg.status_register) | (8'h01 << FBO_C)))
      else $error("carry set wrong");
   carry_clr_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_CARRY_LOW |=> st_reg.status_register ==
      ($past(st_reg.status_register) & ~(8'h01 << FBO_C)))
      else $error("carry clear wrong");
   neg_set_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_NEG_HIGH |=> st_reg.status_register ==
      ($past(st_reg.status_register) | (8'h01 << FBO_N)))
      else $error("negative set wrong");
   neg_clr_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_NEG_LOW |=> st_reg.status_register ==
      ($past(st_reg.status_register) & ~(8'h01 << FBO_N)))
      else $error("negative clear wrong");
   zero_set_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_ZERO_HIGH |=> st_reg.status_register ==
      ($past(st_reg.status_register) | (8'h01 << FBO_Z)))
      else $error("zero set wrong");
   zero_clr_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_ZERO_LOW |=> st_reg.status_register ==
      ($past(st_reg.status_register) & ~(8'h01 << FBO_Z)))
      else $error("zero clear wrong");
   irq_on_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_IRQ_ON |=> st_reg.status_register ==
      ($past(st_reg.status_register) | (8'h01 << FBO_I)))
      else $error("interrupt enable wrong");
   irq_off_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_IRQ_OFF |=> st_reg.status_register ==
      ($past(st_reg.status_register) & ~(8'h01 << FBO_I)))
      else $error("interrupt disable wrong");
   sign_set_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_SIGN_HIGH |=> st_reg.status_register ==
      ($past(st_reg.status_register) | (8'h01 << FBO_S)))
      else $error("sign set wrong");
   sign_clr_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_SIGN_LOW |=> st_reg.status_register ==
      ($past(st_reg.status_register) & ~(8'h01 << FBO_S)))
      else $error("sign clear wrong");
   ovf_set_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_OVF_HIGH |=> st_reg.status_register ==
      ($past(st_reg.status_register) | (8'h01 << FBO_V)))
      else $error("overflow set wrong");
   ovf_clr_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_OVF_LOW |=> st_reg.status_register ==
      ($past(st_reg.status_register) & ~(8'h01 << FBO_V)))
      else $error("overflow clear wrong");
   t_set_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_XFER_HIGH |=> st_reg.status_register ==
      ($past(st_reg.status_register) | (8'h01 << FBO_T)))
      else $error("transfer set wrong");
   t_clr_a: assert property (@(posedge ref_clk) disable iff (srst)
      req.op == FBO_OP_XFER_LOW |=> st_reg.status_register ==
      ($past(st_reg.status_register) & ~(8'h01 << FBO_T)))
      else $error("transfer clear wrong");

   // ****************************************
   // Covers
   // ****************************************
   ror_seen_c: cover property (@(posedge ref_clk) req.op == FBO_OP_ROR);
   store_load_c: cover property (@(posedge ref_clk)
      req.op == FBO_OP_BIT_STORE ##1 req.op == FBO_OP_BIT_LOAD);
   swap_c: cover property (@(posedge ref_clk) req.op == FBO_OP_SWAP);
   ashr_seen_c: cover property (@(posedge ref_clk) req.op == FBO_OP_ARITH_SHR);
   fset_irq_c: cover property (@(posedge ref_clk) req.op == FBO_OP_FSET && req.idx == 3'h7);
endmodule : fbo_unit

// ### testbench/fbo_core_model.sv
// Purpose: Core side general register that takes write-backs from the unit
// Assumes: One register, written whenever result_we pulses outside reset; srst wins
// Notes: Gives the bench a live destination value to feed back
`timescale 1ns/1ps
module fbo_core_model
   import fbo_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire fbo_state_s state_out,
   output logic [7:0] gp_reg
);
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         gp_reg <= FBO_RST_DATA;
      end else if (state_out.result_we) begin
         gp_reg <= state_out.result;
      end
   end
endmodule : fbo_core_model

// ### testbench/fbo_unit_tb.sv
// Purpose: Self-checking bench for the flag and bit operations unit
// Assumes: Requests change on the falling edge, outputs checked one cycle later
// Notes: Fixed-seed random operations with corner cases in front
`timescale 1ns/1ps
module fbo_unit_tb;
   import fbo_pkg::*;
   localparam int flag_pos [7] = '{FBO_C, FBO_N, FBO_Z, FBO_I, FBO_S, FBO_V, FBO_T};
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   fbo_req_s req = '0;
   fbo_state_s state_out;
   fbo_state_s exp_s = '0;
   logic [7:0] gp_reg;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   fbo_unit DUT (.ref_clk(ref_clk), .srst(srst), .req(req), .state_out(state_out));
   fbo_core_model core (.ref_clk(ref_clk), .srst(srst), .state_out(state_out), .gp_reg(gp_reg));
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc = cyc + 1;
      if (cyc == 2000) begin
         err_total++;
         close_out();
      end
   end
   function automatic fbo_state_s predict(fbo_state_s e, fbo_req_s q);
      logic [7:0] r;
      int k;
      r = q.dest;
      e.result_we = q.op inside {FBO_OP_ROR, FBO_OP_ARITH_SHR, FBO_OP_SWAP, FBO_OP_BIT_LOAD};
      case (q.op)
         FBO_OP_ROR, FBO_OP_ARITH_SHR: begin
            r = {(q.op == FBO_OP_ROR) ? e.status_register[FBO_C] : q.dest[7], q.dest[7:1]};
            e.status_register[FBO_C] = q.dest[0];
            e.status_register[FBO_N] = r[7];
            e.status_register[FBO_V] = r[7] ^ q.dest[0];
            e.status_register[FBO_S] = q.dest[0];
            e.status_register[FBO_Z] = (r == 8'h00);
         end
         FBO_OP_SWAP: r = {q.dest[3:0], q.dest[7:4]};
         FBO_OP_FSET: e.status_register[q.idx] = 1'b1;
         FBO_OP_FCLR: e.status_register[q.idx] = 1'b0;
         FBO_OP_BIT_STORE: e.status_register[FBO_T] = q.src[q.idx];
         FBO_OP_BIT_LOAD: r[q.idx] = e.status_register[FBO_T];
         default: begin
            if (q.op >= FBO_OP_CARRY_HIGH && q.op <= FBO_OP_XFER_LOW) begin
               k = (int'(q.op) - int'(FBO_OP_CARRY_HIGH)) / 2;
               e.status_register[flag_pos[k]] = ~q.op[0];
            end
         end
      endcase
      if (e.result_we) begin
         e.result = r;
      end
      return e;
   endfunction : predict
   task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp8
   task automatic cmp1(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask : cmp1
   task automatic step(input fbo_op_e op, input logic [2:0] idx, input logic [7:0] d,
                       input logic [7:0] s);
      req = '{op, idx, d, s};
      exp_s = predict(exp_s, req);
      @(negedge ref_clk);
      cmp8("status", exp_s.status_register, state_out.status_register);
      cmp8("result", exp_s.result, state_out.result);
      cmp1("result_we", exp_s.result_we, state_out.result_we);
   endtask : step
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out
   // ****************
   // Tests
   // ****************
   initial begin
      logic [7:0] d;
      void'($urandom(63));
      repeat (4) @(negedge ref_clk);
      srst = 1'b0;
      step(FBO_OP_NONE, 3'h0, 8'h00, 8'h00);
      step(FBO_OP_CARRY_HIGH, 3'h0, 8'h00, 8'h00);
      step(FBO_OP_ROR, 3'h0, 8'h81, 8'h00);
      step(FBO_OP_ROR, 3'h0, 8'h00, 8'h00);
      step(FBO_OP_ARITH_SHR, 3'h0, 8'h81, 8'h00);
      step(FBO_OP_ARITH_SHR, 3'h0, 8'h01, 8'h00);
      step(FBO_OP_SWAP, 3'h0, 8'hA5, 8'h00);
      step(FBO_OP_FSET, 3'h7, 8'h00, 8'h00);
      step(FBO_OP_IRQ_OFF, 3'h0, 8'h00, 8'h00);
      step(FBO_OP_SIGN_HIGH, 3'h0, 8'h00, 8'h00);
      step(FBO_OP_OVF_HIGH, 3'h0, 8'h00, 8'h00);
      step(FBO_OP_XFER_HIGH, 3'h0, 8'h00, 8'h00);
      step(FBO_OP_BIT_LOAD, 3'h2, 8'h00, 8'h00);
      step(FBO_OP_XFER_LOW, 3'h0, 8'h00, 8'h00);
      step(FBO_OP_BIT_STORE, 3'h5, 8'h00, 8'h20);
      step(fbo_op_e'(5'h1F), 3'h0, 8'h3C, 8'hFF);
      $display("test corners done");
      for (int k = 1; k < 22; k++) begin
         step(fbo_op_e'(k), 3'($urandom), 8'($urandom), 8'($urandom));
      end
      $display("test all_codes done");
      for (int k = 0; k < 400; k++) begin
         d = ($urandom & 1) ? gp_reg : 8'($urandom);
         step(fbo_op_e'($urandom_range(21, 0)), 3'($urandom), d, 8'($urandom));
      end
      $display("test random done");
      // Mid-run reset: state must return to its reset values
      srst = 1'b1;
      @(negedge ref_clk);
      cmp8("status_reset", FBO_RST_STATUS, state_out.status_register);
      cmp8("result_reset", FBO_RST_DATA, state_out.result);
      cmp1("result_we_reset", 1'b0, state_out.result_we);
      srst = 1'b0;
      exp_s = '{status_register: FBO_RST_STATUS, result: FBO_RST_DATA, result_we: 1'b0};
      step(FBO_OP_ROR, 3'h0, 8'h01, 8'h00);
      $display("test reset done");
      close_out();
   end
endmodule : fbo_unit_tb
